// ### common/mps_pkg.sv
// Constants, register map, command bits and state types of the magnetizer pulse sequencer
package mps_pkg;

    // Clock rate in MHz, used to turn microsecond times into cycle counts
    localparam int CLK_MHZ = 200;

    // Times in microseconds
    localparam int T_RECHARGE_US = 50000;  // recharge_wait_time, reservoir recharge
    localparam int T_PULSE_US    = 1000;   // pulse_complete_time, forward or reverse pulse
    localparam int T_MEAS_BW0_US = 10000;  // measurement_time, bandwidth_select 00
    localparam int T_MEAS_BW1_US = 5000;   // measurement_time, bandwidth_select 01
    localparam int T_MEAS_BW2_US = 3000;   // measurement_time, bandwidth_select 10
    localparam int T_MEAS_BW3_US = 1500;   // measurement_time, bandwidth_select 11
    localparam int T_POWERUP_US  = 10000;  // powerup_wait_time, kept by the host

    // Cycle counts derived from the times, whole microseconds at an integer MHz rate
    localparam int RECHARGE_CYC = T_RECHARGE_US * CLK_MHZ;
    localparam int PULSE_CYC    = T_PULSE_US * CLK_MHZ;
    localparam int MEAS_BW0_CYC = T_MEAS_BW0_US * CLK_MHZ;
    localparam int MEAS_BW1_CYC = T_MEAS_BW1_US * CLK_MHZ;
    localparam int MEAS_BW2_CYC = T_MEAS_BW2_US * CLK_MHZ;
    localparam int MEAS_BW3_CYC = T_MEAS_BW3_US * CLK_MHZ;

    // Serial bus addressing
    localparam logic [3:0] ADDR_HIGH   = 4'h6;   // Fixed upper four address bits 0110
    localparam logic [2:0] ADDR_LOW_DF = 3'h0;   // Factory bits, arbitrary default
    localparam logic [3:0] BIT_COUNT_ACK = 4'h8; // Bit count at the ninth clock
    localparam logic [3:0] BIT_COUNT_END = 4'h9; // Bit count after the ninth clock

    // Register indexes
    localparam logic [7:0] REG_STATUS    = 8'h06;
    localparam logic [7:0] REG_MAIN_CTRL = 8'h07;

    // Field positions
    localparam int BIT_RECHARGE  = 7;
    localparam int BIT_REVERSE   = 6;
    localparam int BIT_FORWARD   = 5;
    localparam int BIT_TAKE_MEAS = 0;
    localparam int BIT_MEAS_DONE = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Serial bus slave states
    typedef enum logic [4:0]
    {
        BUS_IDLE  = 5'b00001,
        BUS_ADDR  = 5'b00010,
        BUS_REG   = 5'b00100,
        BUS_WRITE = 5'b01000,
        BUS_READ  = 5'b10000
    } mps_bus_type;

    // Sequencer states
    typedef enum logic [4:0]
    {
        SEQ_IDLE     = 5'b00001,
        SEQ_RECHARGE = 5'b00010,
        SEQ_FORWARD  = 5'b00100,
        SEQ_REVERSE  = 5'b01000,
        SEQ_MEASURE  = 5'b10000
    } mps_seq_type;

endpackage

// ### rtl/mps_top.sv
// Serial register slave and conditioning pulse and measurement sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: Host sends start, address 0110xxx, write
// RULE_02: Device acknowledges address and index bytes
// RULE_03: Host selects main control register index 07
// RULE_04: Writing 80 recharges the pulse reservoir
// RULE_05: Host waits 50 ms before a pulse
// RULE_06: Writing 20 fires a forward pulse
// RULE_07: Writing 40 fires a reverse pulse
// RULE_08: Forward and reverse give opposite magnetization
// RULE_09: Host waits 1 ms after a pulse
// RULE_10: Host waits bandwidth dependent measurement time
// RULE_11: Host idles 10 ms after supply valid
// RULE_12: Host order: forward, measure, reverse, measure
// RULE_13: Host halves difference and sum for field
// RULE_14: Reverse step is optional for the host
// RULE_15: Writing 01 starts a three axis acquisition
// RULE_16: Status bit 0 flags data available
// RULE_17: Low power follows a finished acquisition
// RULE_18: Command bits clear themselves when done
module mps_top
#(
    parameter logic [2:0] ADDR_LOW     = mps_pkg::ADDR_LOW_DF,  // Factory address bits, arbitrary value
    parameter int         TMR_W        = 24,                    // Timer width
    parameter int         RECHARGE_CYC = mps_pkg::RECHARGE_CYC,
    // Pulse length follows the recharge length at the fixed ratio of the two wait times
    parameter int         PULSE_CYC    = RECHARGE_CYC / (mps_pkg::T_RECHARGE_US / mps_pkg::T_PULSE_US),
    parameter int         MEAS_BW0_CYC = mps_pkg::MEAS_BW0_CYC,
    parameter int         MEAS_BW1_CYC = mps_pkg::MEAS_BW1_CYC,
    parameter int         MEAS_BW2_CYC = mps_pkg::MEAS_BW2_CYC,
    parameter int         MEAS_BW3_CYC = mps_pkg::MEAS_BW3_CYC
)
(
    input  wire logic       SYS_CLK,           // System clock
    input  wire logic       SYS_RST,           // Synchronous reset
    input  wire logic       SCL_IN,            // Bus clock pin
    input  wire logic       SDA_IN,            // Bus data pin level
    output logic            SDA_OUT,           // Bus data drive value
    output logic            SDA_OE_N,          // Bus data drive enable
    input  wire logic [1:0] BANDWIDTH_SELECT,  // bandwidth_select
    output logic            RECHARGE_ACTIVE,   // Reservoir recharging
    output logic            FWD_PULSE,         // Forward pulse in progress
    output logic            REV_PULSE,         // Reverse pulse in progress
    output logic            MAG_POLARITY,      // Magnetization direction
    output logic            MEAS_ACTIVE,       // Acquisition running
    output logic            LOW_POWER          // Low power state
);
    import mps_pkg::*;

    // Pin synchronisers, filtered levels and their previous values
    logic [1:0]  s1_r, s2_r, s3_r;            // Three stage chains, bit 0 clock, bit 1 data
    logic [1:0]  flt_r, flt_nxt;              // Filtered pin levels
    logic [1:0]  prev_r;                      // Filtered levels one cycle earlier
    logic        scl_f, sda_f;                // Filtered clock and data
    logic        scl_rise, scl_fall;          // Bus clock edges
    logic        start_det, stop_det;         // Bus conditions

    // Bus slave state
    mps_bus_type bus_r, bus_nxt;              // Slave state
    logic [3:0]  cnt_r, cnt_nxt;              // Rising edges seen in this byte
    logic [7:0]  shift_r, shift_nxt;          // Received byte
    logic [7:0]  tx_r, tx_nxt;                // Byte being sent
    logic [7:0]  ptr_r, ptr_nxt;              // Register index
    logic        ack_r, ack_nxt;              // Driving an acknowledge
    logic        nack_r, nack_nxt;            // Master declined the last byte
    logic        wr_stb;                      // Register write in this cycle

    // Registers and sequencer state
    logic [7:0]  ctrl_r, ctrl_nxt;            // main_control
    logic [7:0]  clr;                         // Command bits finishing now
    logic        done_r, done_nxt;            // Data available flag
    logic        pol_r, pol_nxt;              // Magnetization direction
    mps_seq_type seq_r, seq_nxt;              // Sequencer state
    logic [TMR_W-1:0] tmr_r, tmr_nxt;         // Action timer
    logic [7:0]  status;                      // Status register image

    // Each pin passes three flops; the level moves once stages two and three agree
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
        always_comb
        begin
            flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
        end
    end

    // Synchroniser and filter registers
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            s1_r   <= 2'h3;
            s2_r   <= 2'h3;
            s3_r   <= 2'h3;
            flt_r  <= 2'h3;
            prev_r <= 2'h3;
        end
        else
        begin
            s1_r   <= {SDA_IN, SCL_IN};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            flt_r  <= flt_nxt;
            prev_r <= flt_r;
        end
    end

    // Edges and bus conditions from the filtered levels
    assign scl_f     = flt_r[0];
    assign sda_f     = flt_r[1];
    assign scl_rise  = scl_f & ~prev_r[0];
    assign scl_fall  = ~scl_f & prev_r[0];
    assign start_det = scl_f & prev_r[0] & prev_r[1] & ~sda_f;
    assign stop_det  = scl_f & prev_r[0] & ~prev_r[1] & sda_f;

    // Status image: data available in bit 0, other bits zero
    always_comb
    begin
        status                = STATUS_RESET;
        status[BIT_MEAS_DONE] = done_r;  // see RULE_16
    end

    // Read data decode by register index
    function automatic logic [7:0] rd_data(input logic [7:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx == REG_STATUS)
            val = status;
        else if (idx == REG_MAIN_CTRL)
            val = ctrl_r;
        else
            val = 8'h00;
        return val;
    endfunction

    // Bus slave next state
    always_comb
    begin
        bus_nxt   = bus_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        tx_nxt    = tx_r;
        ptr_nxt   = ptr_r;
        ack_nxt   = ack_r;
        nack_nxt  = nack_r;
        wr_stb    = 1'b0;
        if (start_det)
        begin
            // Start or repeated start: expect an address byte
            bus_nxt = BUS_ADDR;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            // Stop: release the bus
            bus_nxt = BUS_IDLE;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
        end
        else if (bus_r != BUS_IDLE)
        begin
            if (scl_rise)
            begin
                // Sample a data bit, or the master's answer on the ninth clock
                if (cnt_r < BIT_COUNT_ACK)
                    shift_nxt = {shift_r[6:0], sda_f};
                else
                    nack_nxt = sda_f;
                cnt_nxt = 4'(cnt_r + 4'h1);
            end
            else if (scl_fall)
            begin
                if (cnt_r == BIT_COUNT_ACK)
                begin
                    // Byte complete: acknowledge what belongs to us
                    case (bus_r)
                        BUS_ADDR:
                        begin
                            if (shift_r[7:1] == {ADDR_HIGH, ADDR_LOW})
                                ack_nxt = 1'b1;  // see RULE_02
                            else
                                bus_nxt = BUS_IDLE;
                        end
                        BUS_REG:
                        begin
                            ptr_nxt = shift_r;
                            ack_nxt = 1'b1;  // see RULE_02
                        end
                        BUS_WRITE:
                        begin
                            wr_stb  = 1'b1;
                            ack_nxt = 1'b1;
                        end
                        BUS_READ:
                        begin
                            // Last data bit over: let go for the master's answer
                            tx_nxt = 8'hFF;
                        end
                        default:
                        begin
                            ack_nxt = 1'b0;
                        end
                    endcase
                end
                else if (cnt_r == BIT_COUNT_END)
                begin
                    // Ninth clock over: release and move on
                    ack_nxt = 1'b0;
                    cnt_nxt = 4'h0;
                    case (bus_r)
                        BUS_ADDR:
                        begin
                            if (shift_r[0])
                            begin
                                bus_nxt = BUS_READ;
                                tx_nxt  = rd_data(ptr_r);
                            end
                            else
                                bus_nxt = BUS_REG;
                        end
                        BUS_REG:
                            bus_nxt = BUS_WRITE;
                        BUS_WRITE:
                            ptr_nxt = 8'(ptr_r + 8'h01);
                        BUS_READ:
                        begin
                            if (nack_r)
                                bus_nxt = BUS_IDLE;
                            else
                            begin
                                ptr_nxt = 8'(ptr_r + 8'h01);
                                tx_nxt  = rd_data(8'(ptr_r + 8'h01));
                            end
                        end
                        default:
                            bus_nxt = BUS_IDLE;
                    endcase
                end
                else if (bus_r == BUS_READ && cnt_r != 4'h0)
                    tx_nxt = {tx_r[6:0], 1'b0};  // Present the next bit
            end
        end
    end

    // Bus slave registers
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            bus_r   <= BUS_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            tx_r    <= 8'h00;
            ptr_r   <= 8'h00;
            ack_r   <= 1'b0;
            nack_r  <= 1'b0;
        end
        else
        begin
            bus_r   <= bus_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            ack_r   <= ack_nxt;
            nack_r  <= nack_nxt;
        end
    end

    // Open drain data: only ever pulled low
    assign SDA_OUT  = 1'b0;
    // Read bits stand until the fall that ends the eighth clock
    assign SDA_OE_N = ~(ack_r | (bus_r == BUS_READ && cnt_r <= BIT_COUNT_ACK && !tx_r[7]));

    // Sequencer next state: one action at a time, recharge first
    always_comb
    begin
        seq_nxt  = seq_r;
        tmr_nxt  = tmr_r;
        pol_nxt  = pol_r;
        done_nxt = done_r;
        clr      = 8'h00;
        case (seq_r)
            SEQ_IDLE:
            begin
                if (ctrl_r[BIT_RECHARGE])
                begin
                    seq_nxt = SEQ_RECHARGE;  // see RULE_04
                    tmr_nxt = TMR_W'(RECHARGE_CYC - 1);
                end
                else if (ctrl_r[BIT_FORWARD])
                begin
                    seq_nxt = SEQ_FORWARD;  // see RULE_06
                    pol_nxt = 1'b1;         // see RULE_08
                    tmr_nxt = TMR_W'(PULSE_CYC - 1);
                end
                else if (ctrl_r[BIT_REVERSE])
                begin
                    seq_nxt = SEQ_REVERSE;  // see RULE_07
                    pol_nxt = 1'b0;         // see RULE_08
                    tmr_nxt = TMR_W'(PULSE_CYC - 1);
                end
                else if (ctrl_r[BIT_TAKE_MEAS])
                begin
                    seq_nxt  = SEQ_MEASURE;  // see RULE_15
                    done_nxt = 1'b0;
                    case (BANDWIDTH_SELECT)
                        2'h0:    tmr_nxt = TMR_W'(MEAS_BW0_CYC - 1);
                        2'h1:    tmr_nxt = TMR_W'(MEAS_BW1_CYC - 1);
                        2'h2:    tmr_nxt = TMR_W'(MEAS_BW2_CYC - 1);
                        default: tmr_nxt = TMR_W'(MEAS_BW3_CYC - 1);
                    endcase
                end
            end
            default:
            begin
                if (tmr_r == '0)
                begin
                    // Action over: drop its command bit and go back to low power
                    seq_nxt = SEQ_IDLE;  // see RULE_17
                    case (seq_r)
                        SEQ_RECHARGE: clr[BIT_RECHARGE] = 1'b1;  // see RULE_18
                        SEQ_FORWARD:  clr[BIT_FORWARD]  = 1'b1;  // see RULE_18
                        SEQ_REVERSE:  clr[BIT_REVERSE]  = 1'b1;  // see RULE_18
                        default:
                        begin
                            clr[BIT_TAKE_MEAS] = 1'b1;  // see RULE_18
                            done_nxt           = 1'b1;  // see RULE_16
                        end
                    endcase
                end
                else
                    tmr_nxt = TMR_W'(tmr_r - 1'b1);
            end
        endcase
        // A host write in the finishing cycle wins over the self clear
        if (wr_stb && ptr_r == REG_MAIN_CTRL)
            ctrl_nxt = shift_r;
        else
            ctrl_nxt = ctrl_r & ~clr;
    end

    // Sequencer and register file registers
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            seq_r  <= SEQ_IDLE;
            tmr_r  <= '0;
            pol_r  <= 1'b0;
            done_r <= 1'b0;
            ctrl_r <= CTRL_RESET;
        end
        else
        begin
            seq_r  <= seq_nxt;
            tmr_r  <= tmr_nxt;
            pol_r  <= pol_nxt;
            done_r <= done_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // Status outputs straight from the sequencer flops
    assign RECHARGE_ACTIVE = (seq_r == SEQ_RECHARGE);
    assign FWD_PULSE       = (seq_r == SEQ_FORWARD);
    assign REV_PULSE       = (seq_r == SEQ_REVERSE);
    assign MEAS_ACTIVE     = (seq_r == SEQ_MEASURE);
    assign LOW_POWER       = (seq_r == SEQ_IDLE);
    assign MAG_POLARITY    = pol_r;

    // Checks on the bus slave and the sequencer
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_addr_done;
        bus_r == BUS_ADDR && scl_fall && !start_det && !stop_det && cnt_r == 4'h8;
    endsequence
    sequence s_action_end;
        seq_r != SEQ_IDLE && tmr_r == '0;
    endsequence

    a_addr_ack: assert property (s_addr_done ##0 shift_r[7:1] == {ADDR_HIGH, ADDR_LOW} |=> !SDA_OE_N) // see RULE_02
        else $error("address byte not acknowledged");
    a_reg_ack: assert property (bus_r == BUS_REG && scl_fall && !stop_det && !start_det && cnt_r == 4'h8
        |=> !SDA_OE_N && ptr_r == $past(shift_r)) // see RULE_02
        else $error("index byte not acknowledged");
    a_recharge_go: assert property (LOW_POWER && ctrl_r[BIT_RECHARGE] |=> RECHARGE_ACTIVE [*8]) // see RULE_04
        else $error("recharge did not start");
    a_forward_go: assert property (LOW_POWER && ctrl_r == 8'h20 |=> FWD_PULSE && MAG_POLARITY) // see RULE_06
        else $error("forward pulse did not start");
    a_reverse_go: assert property (LOW_POWER && ctrl_r == 8'h40 |=> REV_PULSE && !MAG_POLARITY) // see RULE_07
        else $error("reverse pulse did not start");
    a_polarity_hold: assert property (!LOW_POWER |=> $stable(MAG_POLARITY)) // see RULE_08
        else $error("polarity changed during an action");
    a_meas_go: assert property (LOW_POWER && ctrl_r == 8'h01 |=> MEAS_ACTIVE && !status[BIT_MEAS_DONE]) // see RULE_15
        else $error("measurement did not start");
    a_done_flag: assert property (s_action_end ##0 MEAS_ACTIVE |=> status[BIT_MEAS_DONE] && LOW_POWER) // see RULE_16
        else $error("data available flag or low power missing");
    a_low_power: assert property (s_action_end |=> LOW_POWER) // see RULE_17
        else $error("low power not entered after action");
    a_cmd_clear: assert property (s_action_end ##0 RECHARGE_ACTIVE && !wr_stb |=> !ctrl_r[BIT_RECHARGE]) // see RULE_18
        else $error("recharge bit not cleared");

endmodule // mps_top
`default_nettype wire

// ### verification/mps_host_model.sv
// Host bus master model: drives the serial clock and pulls the data wire low
`timescale 1ns/1ps
`default_nettype none
module mps_host_model
(
    input  wire logic sys_clk,  // Bench clock, pins change at its falling edge
    input  wire logic sda,      // Resolved data wire, pulled up when released
    output logic      scl,      // Serial clock, high while idle
    output logic      sda_low   // Master pulls the data wire low
);
    // Bus idles released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One half bit phase, ten system cycles
    task automatic half();
        repeat (10) @(negedge sys_clk);
    endtask

    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask

    // Stop: data rises while clock high
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask

    // One bit; data set in the low phase, sampled five cycles into the fifteen cycle high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        half();
        scl = 1'b1;
        repeat (5) @(negedge sys_clk);
        r = sda;
        half();
        scl = 1'b0;
        repeat (5) @(negedge sys_clk);
    endtask

    // Eight bits MSB first, then the ninth clock with data released
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, a);
        ack = ~a;
    endtask

    // Register write: address with write bit, index, one data byte
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx, input logic [7:0] data,
                             output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        start();
        byte_io({addr, 1'b0}, q, a0);
        byte_io(idx, q, a1);
        byte_io(data, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // Register read: set index, repeated start, one byte closed by a not-acknowledge
    task automatic read_reg(input logic [6:0] addr, input logic [7:0] idx, output logic [7:0] q,
                            output logic ok);
        logic a0;
        logic a1;
        logic a2;
        logic na;
        start();
        byte_io({addr, 1'b0}, q, a0);
        byte_io(idx, q, a1);
        start();
        byte_io({addr, 1'b1}, q, a2);
        byte_io(8'hFF, q, na);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // mps_host_model
`default_nettype wire

// ### verification/tb_magnetizer_pulse_sequencer.sv
// Self-checking bench: command writes, action lengths, status and polarity
`timescale 1ns/1ps
`default_nettype none
module tb_magnetizer_pulse_sequencer;
    import mps_pkg::*;
    localparam logic [6:0] DEV_ADDR = {ADDR_HIGH, ADDR_LOW_DF};  // Default factory bits
    localparam int         RECH_N   = 250;  // Shortened recharge length
    localparam int         PULSE_N  = 5;    // Pulse is one fiftieth of the recharge
    localparam int         MEAS_CYC [4] = '{60, 40, 30, 20};
    logic       sys_clk;
    logic       sys_rst;
    logic       scl;
    logic       sda_low;
    logic       sda_wire;
    logic       sda_out;
    logic       sda_oe_n;
    logic [1:0] bw;
    logic       rech, fwd, rev, pol, meas, lowp;
    logic [3:0] act;
    logic [7:0] q;
    logic       ok;
    logic       pol_fwd;  // Polarity seen after the forward pulse
    int         run [4] = '{default: 0};  // Current high run of each action
    int         last [4] = '{default: 0};  // Length of the last finished run
    int         n_mismatch = 0;
    int         total_checks = 0;
    int         cycles = 0;

    // Wired-and data line with pull-up
    assign sda_wire = ~(sda_low | ~sda_oe_n);
    assign act = {meas, rev, fwd, rech};

    mps_top #(.RECHARGE_CYC(RECH_N), .MEAS_BW0_CYC(60),
              .MEAS_BW1_CYC(40), .MEAS_BW2_CYC(30), .MEAS_BW3_CYC(20)) mps_top_inst
    (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .BANDWIDTH_SELECT(bw), .RECHARGE_ACTIVE(rech), .FWD_PULSE(fwd),
        .REV_PULSE(rev), .MAG_POLARITY(pol), .MEAS_ACTIVE(meas), .LOW_POWER(lowp)
    );
    mps_host_model mps_host_model_inst (.sys_clk(sys_clk), .sda(sda_wire), .scl(scl), .sda_low(sda_low));

    // Clock, 5 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Run-length monitor of the four action outputs; hang limit
    always @(posedge sys_clk)
    begin
        for (int k = 0; k < 4; k++)
        begin
            last[k] <= (act[k] === 1'b1 || run[k] == 0) ? last[k] : run[k];
            run[k] <= (act[k] === 1'b1) ? run[k] + 1 : 0;
        end
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write one command, wait for its action to end, check its length and self clear
    task automatic run_cmd(input logic [7:0] cmd, input int k, input int n);
        last[k] = 0;
        mps_host_model_inst.write_reg(DEV_ADDR, REG_MAIN_CTRL, cmd, ok);
        check({7'h00, ok}, 8'h01);
        for (int i = 0; i < 400 && last[k] == 0; i++)
            @(negedge sys_clk);
        check(last[k][7:0], n[7:0]);
        check({7'h00, lowp}, 8'h01);
        mps_host_model_inst.read_reg(DEV_ADDR, REG_MAIN_CTRL, q, ok);
        check(q, CTRL_RESET);
    endtask

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence: recharge, forward, measure, recharge, reverse, then a measure at each bandwidth
    initial
    begin
        sys_rst = 1'b1;
        bw = 2'h0;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (20) @(negedge sys_clk);
        check({2'h0, sda_out, sda_oe_n, pol, lowp, rech, meas}, 8'h14);
        run_cmd(8'h80, 0, RECH_N);
        run_cmd(8'h20, 1, PULSE_N);
        check({7'h00, pol}, 8'h01);
        pol_fwd = pol;
        run_cmd(8'h01, 3, MEAS_CYC[0]);
        run_cmd(8'h80, 0, RECH_N);
        run_cmd(8'h40, 2, PULSE_N);
        check({7'h00, pol}, 8'h00);
        check({7'h00, pol_fwd ^ pol}, 8'h01);
        for (int b = 0; b < 4; b++)
        begin
            bw = b[1:0];
            run_cmd(8'h01, 3, MEAS_CYC[b]);
            mps_host_model_inst.read_reg(DEV_ADDR, REG_STATUS, q, ok);
            check(q, 8'h01);
        end
        mps_host_model_inst.write_reg(DEV_ADDR ^ 7'h01, REG_MAIN_CTRL, 8'h20, ok);
        check({7'h00, ok}, 8'h00);
        repeat (40) @(negedge sys_clk);
        check({7'h00, pol}, 8'h00);
        mps_host_model_inst.read_reg(DEV_ADDR, 8'h10, q, ok);
        check(q, 8'h00);
        print_verdict();
    end
endmodule // tb_magnetizer_pulse_sequencer
`default_nettype wire
